// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, sys_rst, timer_clock, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic pin_a_out, pin_a_oe, pin_an_out, pin_an_oe, overflow_irq;
  logic pin_b_out, pin_b_oe, pin_bn_out, pin_bn_oe;
  int miscompares, n_checks;

  tnf_timer tnf_timer_i (.mclk, .sys_rst, .timer_clock, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_a_out, .pin_a_oe, .pin_an_out, .pin_an_oe,
    .pin_b_out, .pin_b_oe, .pin_bn_out, .pin_bn_oe, .overflow_irq);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----
  // Helpers
  // ----
  task wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (n == 40)
      miscompares++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask

  // One timer tick, spaced well beyond the sync delay
  task tick;
    timer_clock <= 1'b1;
    repeat (3) @(posedge mclk);
    timer_clock <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    wr(5'h18, 32'hff);
    rc(5'h18, 32'h0);
    rc(tnf_pkg::ADDR_COUNT, 32'h0);
    rc(tnf_pkg::ADDR_CTRL, 32'h0);
    rc(tnf_pkg::ADDR_STATUS, 32'h0);
    // Let the answer cycle pass so waitrequest is back to idle
    @(posedge mclk);
    check({22'h0, pin_b_out, pin_b_oe, pin_bn_out, pin_bn_oe, pin_a_out, pin_a_oe, pin_an_out, pin_an_oe,
      overflow_irq, avs_waitrequest}, 32'h89);
  endtask

  task t_normal;
    int i;
    wr(tnf_pkg::ADDR_TOP, 32'h1);
    wr(tnf_pkg::ADDR_CMP_A, 32'h1);
    wr(tnf_pkg::ADDR_CTRL, 32'h1310);
    for (i = 1; i <= 4; i++)
    begin
      tick;
      rc(tnf_pkg::ADDR_STATUS, {30'h0, i == 2 || i == 3, i >= 2});
      rc(tnf_pkg::ADDR_COUNT, i % 2);
      check({30'h0, pin_a_oe, overflow_irq}, {30'h0, 1'b0, i >= 2});
    end
    check({31'h0, pin_an_oe}, 32'h1);
    wr(tnf_pkg::ADDR_CTRL, 32'h3310);
    rc(tnf_pkg::ADDR_STATUS, 32'h0);
    wr(tnf_pkg::ADDR_COUNT, 32'h1);
    tick;
    rc(tnf_pkg::ADDR_STATUS, 32'h1);
    tick;
    tick;
    rc(tnf_pkg::ADDR_STATUS, 32'h3);
    for (i = 2; i <= 3; i++)
    begin
      wr(tnf_pkg::ADDR_CTRL, 32'h3300 | (i << 4));
      tick;
      tick;
      rc(tnf_pkg::ADDR_STATUS, {30'h0, i[0], 1'b1});
      check({30'h0, pin_a_oe, pin_a_out}, {30'h0, 1'b1, !i[0]});
    end
    wr(tnf_pkg::ADDR_CTRL, 32'h1300);
    tick;
    check({30'h0, pin_a_oe, pin_an_oe}, 32'h0);
  endtask

  task t_fast;
    int i, k, c, code;
    wr(tnf_pkg::ADDR_TOP, 32'h3);
    wr(tnf_pkg::ADDR_CMP_A, 32'h2);
    for (k = 0; k < 3; k++)
    begin
      code = (k + 1) % 3 + 1;
      wr(tnf_pkg::ADDR_CTRL, 32'h2301 | (code << 4));
      wr(tnf_pkg::ADDR_COUNT, 32'h0);
      wr(tnf_pkg::ADDR_CTRL, 32'h1301 | (code << 4));
      for (i = 1; i <= 8; i++)
      begin
        tick;
        c = i % 4;
        rc(tnf_pkg::ADDR_COUNT, c);
        // Second tick still shows the wave left by the previous code
        if (i > 1)
          rc(tnf_pkg::ADDR_STATUS, {30'h0, (i == 2) ? (k < 2) : ((c != 3) ^ (code == 3)), i > 2});
      end
      check({30'h0, pin_a_oe, pin_an_oe}, {30'h0, code != 2, code != 3});
    end
    wr(tnf_pkg::ADDR_CTRL, 32'h1309);
    wr(tnf_pkg::ADDR_COUNT, 32'h2);
    tick;
    rc(tnf_pkg::ADDR_COUNT, 32'h2);
  endtask
  // ----
  // Run
  // ----
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up;
  end

  initial
  begin
    sys_rst = 1'b1;
    timer_clock = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    miscompares = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_normal;
    t_fast;
    wrap_up;
  end
endmodule
`default_nettype wire

// ### bench/tnf_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tnf_timer_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs
  input wire logic timer_clock,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  // Outputs
  input wire logic avs_waitrequest,
  input wire logic pin_a_oe,
  input wire logic pin_an_oe,
  input wire logic overflow_irq
);
  // ----
  // Decode
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic req = avs_read || avs_write;
  wire logic cw = avs_write && !avs_waitrequest && avs_address == tnf_pkg::ADDR_CTRL && avs_byteenable[0];
  wire logic ack = cw && avs_writedata[13];
  wire logic en_a = cw && avs_byteenable[1] && avs_writedata[8];
  wire logic en_an = cw && avs_byteenable[1] && avs_writedata[9];
  // ----
  // Properties
  // ----
  chk_wait_answer:
    assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("request not answered");
  chk_wait_once:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  chk_wait_idle:
    assert property (!req && avs_waitrequest |=> avs_waitrequest) else $error("answer without request");
  chk_irq_tick:
    assert property ($rose(overflow_irq) |-> $past(timer_clock, 2) || $past(timer_clock, 3)
      || $past(timer_clock, 4) || $past(timer_clock, 5)) else $error("overflow without tick");
  chk_irq_ack:
    assert property ($fell(overflow_irq) |-> $past(ack) || $past(ack, 2) || $past(ack, 3))
      else $error("overflow cleared without service");
  chk_oe_true:
    assert property ($rose(pin_a_oe) |-> $past(en_a) || $past(en_a, 2) || $past(en_a, 3))
      else $error("true pin driven without direction");
  chk_oe_comp:
    assert property ($rose(pin_an_oe) |-> $past(en_an) || $past(en_an, 2) || $past(en_an, 3))
      else $error("complement pin driven without direction");
  chk_com_off:
    assert property (cw && avs_writedata[5:4] == 2'h0 |-> ##[1:3] (!pin_a_oe && !pin_an_oe))
      else $error("pins still driven with mode off");
endmodule
bind tnf_timer tnf_timer_asserts tnf_timer_asserts_i (.mclk, .sys_rst, .timer_clock, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .pin_a_oe, .pin_an_oe, .overflow_irq);
`default_nettype wire

// ### rtl/tnf_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tnf_chan_if;
  logic [tnf_pkg::CNT_W-1:0] count;
  logic [tnf_pkg::CNT_W-1:0] compare;
  logic [1:0] com;
  logic is_fast;
  logic at_top;
  logic block;
  logic tick;
  logic wave;
  logic pin_true;
  logic pin_comp;
  logic drive_true;
  logic drive_comp;

  modport timer (output count, compare, com, is_fast, at_top, block, tick,
                 input wave, pin_true, pin_comp, drive_true, drive_comp);
  modport chan (input count, compare, com, is_fast, at_top, block, tick,
                output wave, pin_true, pin_comp, drive_true, drive_comp);
endinterface
`default_nettype wire

// ### rtl/tnf_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tnf_channel (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Timer side
  tnf_chan_if.chan ch
);

  // ----------------------------------------
  // Match and waveform
  // ----------------------------------------
  logic wave_reg;
  logic wave_next;
  logic pin_reg;
  logic match;

  assign match = ch.tick && !ch.block && (ch.count == ch.compare); // [R21] [R18]

  always_comb
  begin
    wave_next = wave_reg;
    if (ch.is_fast)
    begin
      if (ch.tick && ch.at_top && ch.com != tnf_pkg::COM_OFF)
        wave_next = (ch.com != tnf_pkg::COM_SET); // [R12] [R14]
      else if (match)
      begin
        if (ch.com == tnf_pkg::COM_SET)
          wave_next = 1'b1; // [R12]
        else if (ch.com != tnf_pkg::COM_OFF)
          wave_next = 1'b0; // [R12] [R13]
      end
    end
    else if (match)
    begin
      case (ch.com) // [R19]
        tnf_pkg::COM_TOGGLE: wave_next = !wave_reg; // [R03] [R09]
        tnf_pkg::COM_CLEAR: wave_next = 1'b0; // [R03]
        tnf_pkg::COM_SET: wave_next = 1'b1; // [R03]
        default: wave_next = wave_reg;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wave_reg <= 1'b0; // [R22]
      pin_reg <= 1'b0;
    end
    else
    begin
      wave_reg <= wave_next;
      if (ch.tick)
        pin_reg <= wave_reg; // [R20]
    end
  end

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  logic fast_true_on;
  logic fast_comp_on;
  assign fast_true_on = (ch.com == tnf_pkg::COM_TOGGLE) || (ch.com == tnf_pkg::COM_SET);
  assign fast_comp_on = (ch.com == tnf_pkg::COM_TOGGLE) || (ch.com == tnf_pkg::COM_CLEAR);

  assign ch.wave = wave_reg;
  assign ch.pin_true = pin_reg;
  assign ch.pin_comp = !pin_reg; // [R13]
  assign ch.drive_true = ch.is_fast ? fast_true_on : (ch.com[1] && !ch.com[0]) || (ch.com == tnf_pkg::COM_SET);
  assign ch.drive_comp = ch.is_fast ? fast_comp_on : (ch.com == tnf_pkg::COM_TOGGLE); // [R04]

endmodule
`default_nettype wire

// ### rtl/tnf_pkg.sv
package tnf_pkg;

  // ----------------------------------------
  // Register map (word-aligned byte offsets)
  // ----------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_COUNT = 5'h04;
  localparam logic [4:0] ADDR_TOP = 5'h08;
  localparam logic [4:0] ADDR_CMP_A = 5'h0c;
  localparam logic [4:0] ADDR_CMP_B = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_PWM_A = 0;
  localparam int CTRL_PWM_B = 1;
  localparam int CTRL_WGM_LO = 2;
  localparam int CTRL_COM_A_LO = 4;
  localparam int CTRL_COM_B_LO = 6;
  localparam int CTRL_DDR_A = 8;
  localparam int CTRL_DDR_AN = 9;
  localparam int CTRL_DDR_B = 10;
  localparam int CTRL_DDR_BN = 11;
  localparam int CTRL_RUN = 12;
  localparam int CTRL_OVF_ACK = 13;
  localparam int CTRL_WIDTH = 13;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int STAT_OVF = 0;
  localparam int STAT_WAVE_A = 1;
  localparam int STAT_WAVE_B = 2;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] TOP_RESET = 8'hff;
  localparam logic [CNT_W-1:0] CMP_RESET = 8'h00;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 13'h0000;

  // ----------------------------------------
  // Compare output and waveform mode codes
  // ----------------------------------------
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [1:0] WGM_FAST = 2'h0;

  // ----------------------------------------
  // Counting sequences
  // ----------------------------------------
  typedef enum logic [1:0] {
    TNF_SEQ_NORMAL,
    TNF_SEQ_FAST,
    TNF_SEQ_OTHER
  } tnf_seq_t;

endpackage

// ### rtl/tnf_timer.sv
// Summary of operation
// [R01] Count sequence comes only from PWM enables and waveform mode field.
// [R02] Normal mode counts up from zero to top, then restarts.
// [R03] Normal mode: toggle, clear or set waveform on compare match.
// [R04] Normal mode code 00 leaves both pins disconnected.
// [R05] Normal mode: counter at top clears to zero next cycle.
// [R06] Normal mode: overflow flag set when counter becomes zero; count never clears it.
// [R07] Overflow flag clears when the overflow interrupt is serviced.
// [R08] Normal mode accepts a counter write at any time.
// [R09] Normal toggle frequency is timer clock over two times one plus top.
// [R10] A compare value reaches its pin only when direction is output.
// [R11] PWM enable with mode field 00 selects single-slope fast PWM.
// [R12] Fast PWM: clear on match, set at zero; inverting is reversed.
// [R13] Fast PWM codes: two non-inverted, three inverted, one complementary. Code two drives only the complement pin, which outputs it inverted.
// [R14] Fast PWM: counter at top clears next tick; bottom action happens there.
// [R15] Fast PWM: overflow flag set when counter reaches top.
// [R16] Fast PWM period is one plus top timer clock steps.
// [R17] Fast PWM with compare zero gives a narrow spike.
// [R18] A counter write blocks all compare matches in the next timer tick.
// [R19] Compare output mode change acts at the first following match.
// [R20] Normal mode pin output follows waveform one timer tick later.
// [R21] Match when counter equals channel compare, once per timer tick.
// [R22] Reset clears counter, flag and waveforms and selects normal mode.
`timescale 1ns/1ps
`default_nettype none
module tnf_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Prescaled timer tick
  input wire logic timer_clock,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Compare pins, channel a
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_an_out,
  output logic pin_an_oe,
  // Compare pins, channel b
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic pin_bn_out,
  output logic pin_bn_oe,
  // Status
  output logic overflow_irq
);

  // ----------------------------------------
  // Tick synchroniser
  // ----------------------------------------
  logic tick_s1_reg;
  logic tick_s2_reg;
  logic tick_d_reg;
  logic tick;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_d_reg <= 1'b0;
    end
    else
    begin
      tick_s1_reg <= timer_clock;
      tick_s2_reg <= tick_s1_reg;
      tick_d_reg <= tick_s2_reg;
    end
  end

  logic [tnf_pkg::CTRL_WIDTH-1:0] ctrl_reg;
  assign tick = tick_s2_reg && !tick_d_reg && ctrl_reg[tnf_pkg::CTRL_RUN];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wait_reg;
  logic access;
  logic wr_ok;
  logic hit_ctrl;
  logic hit_count;
  logic hit_top;
  logic hit_cmp_a;
  logic hit_cmp_b;
  logic hit_status;

  assign access = (avs_read || avs_write) && wait_reg;
  assign wr_ok = access && avs_write && avs_byteenable[0];
  assign hit_ctrl = avs_address == tnf_pkg::ADDR_CTRL;
  assign hit_count = avs_address == tnf_pkg::ADDR_COUNT;
  assign hit_top = avs_address == tnf_pkg::ADDR_TOP;
  assign hit_cmp_a = avs_address == tnf_pkg::ADDR_CMP_A;
  assign hit_cmp_b = avs_address == tnf_pkg::ADDR_CMP_B;
  assign hit_status = avs_address == tnf_pkg::ADDR_STATUS;

  logic count_wr;
  logic ctrl_wr;
  assign count_wr = wr_ok && hit_count;
  assign ctrl_wr = wr_ok && hit_ctrl && avs_byteenable[1];

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  logic [1:0] wgm;
  tnf_pkg::tnf_seq_t seq;
  assign wgm = ctrl_reg[tnf_pkg::CTRL_WGM_LO +: 2];
  assign seq = !(ctrl_reg[tnf_pkg::CTRL_PWM_A] || ctrl_reg[tnf_pkg::CTRL_PWM_B]) ? tnf_pkg::TNF_SEQ_NORMAL :
               (wgm == tnf_pkg::WGM_FAST) ? tnf_pkg::TNF_SEQ_FAST : tnf_pkg::TNF_SEQ_OTHER; // [R01] [R11]

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [tnf_pkg::CNT_W-1:0] count_reg;
  logic [tnf_pkg::CNT_W-1:0] count_next;
  logic [tnf_pkg::CNT_W-1:0] top_reg;
  logic [tnf_pkg::CNT_W-1:0] cmp_a_reg;
  logic [tnf_pkg::CNT_W-1:0] cmp_b_reg;
  logic block_reg;
  logic at_top;
  logic ovf_reg;
  logic ovf_set;

  assign at_top = count_reg == top_reg;

  always_comb
  begin
    count_next = count_reg;
    if (count_wr)
      count_next = avs_writedata[tnf_pkg::CNT_W-1:0]; // [R08]
    else if (tick)
    begin
      case (seq)
        tnf_pkg::TNF_SEQ_NORMAL: count_next = at_top ? tnf_pkg::CNT_RESET : count_reg + 8'h01; // [R02] [R05]
        tnf_pkg::TNF_SEQ_FAST: count_next = at_top ? tnf_pkg::CNT_RESET : count_reg + 8'h01; // [R11] [R14] [R16] [R17]
        default: count_next = count_reg;
      endcase
    end
  end

  // Normal: flag as count wraps to zero; fast: flag when top is reached
  assign ovf_set = tick && !count_wr &&
                   (((seq == tnf_pkg::TNF_SEQ_NORMAL) && at_top) || // [R06]
                    ((seq == tnf_pkg::TNF_SEQ_FAST) && (count_next == top_reg) && !at_top)); // [R15]

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      count_reg <= tnf_pkg::CNT_RESET; // [R22]
      block_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      if (count_wr)
        block_reg <= 1'b1; // [R18]
      else if (tick)
        block_reg <= 1'b0;
    end
  end

  // Set wins over the service acknowledge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ovf_reg <= 1'b0; // [R22]
    else if (ovf_set)
      ovf_reg <= 1'b1; // [R06] [R15]
    else if (ctrl_wr && avs_writedata[tnf_pkg::CTRL_OVF_ACK])
      ovf_reg <= 1'b0; // [R07]
  end

  // ----------------------------------------
  // Control and compare registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= tnf_pkg::CTRL_RESET; // [R22]
      top_reg <= tnf_pkg::TOP_RESET;
      cmp_a_reg <= tnf_pkg::CMP_RESET;
      cmp_b_reg <= tnf_pkg::CMP_RESET;
    end
    else
    begin
      if (wr_ok && hit_ctrl)
        ctrl_reg[7:0] <= avs_writedata[7:0];
      if (ctrl_wr)
        ctrl_reg[12:8] <= avs_writedata[12:8];
      if (wr_ok && hit_top)
        top_reg <= avs_writedata[tnf_pkg::CNT_W-1:0];
      if (wr_ok && hit_cmp_a)
        cmp_a_reg <= avs_writedata[tnf_pkg::CNT_W-1:0];
      if (wr_ok && hit_cmp_b)
        cmp_b_reg <= avs_writedata[tnf_pkg::CNT_W-1:0];
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  tnf_chan_if ch_a ();
  tnf_chan_if ch_b ();

  assign ch_a.count = count_reg;
  assign ch_a.compare = cmp_a_reg;
  assign ch_a.com = ctrl_reg[tnf_pkg::CTRL_COM_A_LO +: 2];
  assign ch_a.is_fast = seq == tnf_pkg::TNF_SEQ_FAST;
  assign ch_a.at_top = at_top;
  assign ch_a.block = block_reg;
  assign ch_a.tick = tick && (seq != tnf_pkg::TNF_SEQ_OTHER);
  assign ch_b.count = count_reg;
  assign ch_b.compare = cmp_b_reg;
  assign ch_b.com = ctrl_reg[tnf_pkg::CTRL_COM_B_LO +: 2];
  assign ch_b.is_fast = seq == tnf_pkg::TNF_SEQ_FAST;
  assign ch_b.at_top = at_top;
  assign ch_b.block = block_reg;
  assign ch_b.tick = tick && (seq != tnf_pkg::TNF_SEQ_OTHER);

  tnf_channel u_chan_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ch(ch_a.chan)
  );

  tnf_channel u_chan_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ch(ch_b.chan)
  );

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_an_out <= 1'b0;
      pin_an_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
      pin_bn_out <= 1'b0;
      pin_bn_oe <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      pin_a_out <= ch_a.pin_true;
      pin_a_oe <= ch_a.drive_true && ctrl_reg[tnf_pkg::CTRL_DDR_A]; // [R10] [R04]
      pin_an_out <= ch_a.pin_comp;
      pin_an_oe <= ch_a.drive_comp && ctrl_reg[tnf_pkg::CTRL_DDR_AN]; // [R10]
      pin_b_out <= ch_b.pin_true;
      pin_b_oe <= ch_b.drive_true && ctrl_reg[tnf_pkg::CTRL_DDR_B]; // [R10]
      pin_bn_out <= ch_b.pin_comp;
      pin_bn_oe <= ch_b.drive_comp && ctrl_reg[tnf_pkg::CTRL_DDR_BN]; // [R10]
      overflow_irq <= ovf_reg;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {19'h00000, ctrl_reg} :
                  hit_count ? {24'h000000, count_reg} :
                  hit_top ? {24'h000000, top_reg} :
                  hit_cmp_a ? {24'h000000, cmp_a_reg} :
                  hit_cmp_b ? {24'h000000, cmp_b_reg} :
                  hit_status ? {29'h00000000, ch_b.wave, ch_a.wave, ovf_reg} : 32'h00000000;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      wait_reg <= (avs_read || avs_write) && !wait_reg;
      avs_waitrequest <= !((avs_read || avs_write) && !wait_reg);
      if (avs_read && !wait_reg)
        avs_readdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire
